// *** core/eeprom_pkg.sv ***
package eeprom_pkg;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  // ----------------------------------------
  // Status layout
  // ----------------------------------------
  localparam int ST_ARM = 7;
  localparam int ST_SEL_HI = 3;
  localparam int ST_SEL_LO = 2;
  localparam int ST_WEL = 1;
  localparam int ST_BUSY = 0;
  localparam logic [7:0] ST_RESET = 8'h00;
  // ----------------------------------------
  // Frame and timing
  // ----------------------------------------
  localparam logic [5:0] BIT_OPC_END = 6'h07;
  localparam logic [5:0] BIT_ADR_END = 6'h17;
  localparam logic [5:0] BIT_STD_END = 6'h0F;
  localparam logic [5:0] BIT_DAT_END = 6'h1F;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam int PAGE_BYTES = 64;
  localparam int WRITE_TIME_MS = 5;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [14:0] PROT_01_BASE = 15'h6000;
  localparam logic [14:0] PROT_10_BASE = 15'h4000;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_QTR = 2'h1;
  localparam logic [1:0] SEL_HALF = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_DONE = 2'b10
  } frame_state_type;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } pins_type;
endpackage

// *** core/spi_eeprom_status_protect.sv ***
`timescale 1ns/1ps
// How it works
// [RQ1] Serial_in sampled on shift_clock rise, opcode, address, data MSB first.
// [RQ2] Serial_out changes on shift_clock fall, MSB first.
// [RQ3] Host sends everything on serial_in and reads only serial_out.
// [RQ4] Status: arm bit7, zeros 6..4, sel_hi 3, sel_lo 2, latch 1, busy 0.
// [RQ5] Block-protect bits change only by status write, kept nonvolatile; the flops are cleared by reset.
// [RQ6] Latch set by set command, cleared by clear command, zero after power-up.
// [RQ7] Memory and status writes execute only while latch is one.
// [RQ8] Busy is one during internal write; host writes to it ignored.
// [RQ9] Protect pin acts only while arm bit is one.
// [RQ10] Select pair blocks writes to quarter, half or all; reads allowed.
// [RQ11] Low protect pin refuses status write when armed; memory writes unaffected.
// [RQ12] Protect pin changes never abort a running internal write.
// [RQ13] Status read returns current status on serial_out.
// [RQ14] Low pause pin suspends the exchange without ending it.
// [RQ15] Host samples on rise, idles clock either level, modes 0 or 3.
// [RQ16] Opcodes 06,04,03,02,05,01; address sixteen bits MSB first.
// [RQ17] Every executed memory write clears the latch.
// [RQ18] Write starts at select rise after last bit, 5 ms, 64-byte page wraps.
// [RQ19] During pause clock and data ignored and serial_out floats.
module spi_eeprom_status_protect
  import eeprom_pkg::*;
#(
  parameter int WRITE_TICKS = WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic shift_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic protect_pin_n,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic busy
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pins_type s1_q, s2_q, s3_q, pin_q;
  pins_type raw;
  assign raw = '{sck: shift_clock, cs_n: chip_select_n, si: serial_in,
                 hold_n: pause_n, wp_n: protect_pin_n};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '{default: 1'b1};
      s2_q <= '{default: 1'b1};
      s3_q <= '{default: 1'b1};
      pin_q <= '{default: 1'b1};
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted only once second and third stages agree, bit by bit
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end
  logic sck_prev_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) sck_prev_q <= 1'b0;
    else sck_prev_q <= pin_q.sck;
  end
  logic held, sck_rise, sck_fall, cs_rise, cs_prev_q;
  assign held = ~pin_q.hold_n; // [RQ14]
  assign sck_rise = pin_q.sck & ~sck_prev_q & ~held & ~pin_q.cs_n; // [RQ19]
  assign sck_fall = ~pin_q.sck & sck_prev_q & ~held & ~pin_q.cs_n; // [RQ19]
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) cs_prev_q <= 1'b1;
    else cs_prev_q <= pin_q.cs_n;
  end
  assign cs_rise = pin_q.cs_n & ~cs_prev_q;

  // ----------------------------------------
  // Memory and status storage
  // ----------------------------------------
  logic [7:0] mem_q [2**15];
  logic arm_q, sel_hi_q, sel_lo_q, wel_q, busy_q;
  logic [7:0] status;
  assign status = {arm_q, 3'b000, sel_hi_q, sel_lo_q, wel_q, busy_q}; // [RQ4]

  // ----------------------------------------
  // Frame decoder
  // ----------------------------------------
  frame_state_type state_q;
  logic [5:0] bit_q;
  logic [7:0] opc_q, sh_q, out_q;
  logic [15:0] adr_q;
  logic [7:0] page_q [PAGE_BYTES];
  logic [6:0] page_cnt_q;
  logic byte_end_q; // Last data bit just taken, no further rise yet
  logic [7:0] opc_next;
  assign opc_next = {opc_q[6:0], pin_q.si};
  logic [7:0] byte_next;
  assign byte_next = {sh_q[6:0], pin_q.si};
  logic in_data;
  assign in_data = bit_q > BIT_ADR_END;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_q <= '0;
      opc_q <= '0;
      sh_q <= '0;
      adr_q <= '0;
      page_cnt_q <= '0;
      byte_end_q <= 1'b0;
    end else if (pin_q.cs_n) begin
      state_q <= ST_IDLE;
      bit_q <= '0;
      page_cnt_q <= '0;
      byte_end_q <= 1'b0;
    end else if (sck_rise) begin // [RQ1]
      state_q <= ST_CMD;
      byte_end_q <= 1'b0;
      if (bit_q <= BIT_OPC_END) opc_q <= opc_next; // [RQ16]
      else if (bit_q <= BIT_ADR_END) adr_q <= {adr_q[14:0], pin_q.si}; // [RQ16]
      sh_q <= byte_next;
      if (bit_q != 6'h3F) bit_q <= bit_q + 6'h01;
      if (opc_q == OP_WRITE && in_data && bit_q[2:0] == BYTE_LAST) begin
        page_q[adr_q[5:0] + page_cnt_q[5:0]] <= byte_next; // [RQ18]
        if (page_cnt_q != 7'(PAGE_BYTES)) page_cnt_q <= page_cnt_q + 7'h01;
        byte_end_q <= 1'b1;
      end
      if (opc_q == OP_STAT_WR && bit_q == BIT_STD_END) byte_end_q <= 1'b1;
      if (opc_q == OP_READ && bit_q > BIT_ADR_END && bit_q[2:0] == BYTE_LAST)
        adr_q <= adr_q + 16'h0001;
    end
  end

  // Opcode latches at the eighth rise, executed immediately
  logic opc_done;
  assign opc_done = sck_rise & ~pin_q.cs_n & (bit_q == BIT_OPC_END);

  // ----------------------------------------
  // Protection and write cycle
  // ----------------------------------------
  function automatic logic blocked(input logic [14:0] a, input logic [1:0] sel);
    case (sel) // [RQ10]
      SEL_NONE: blocked = 1'b0;
      SEL_QTR: blocked = a >= PROT_01_BASE;
      SEL_HALF: blocked = a >= PROT_10_BASE;
      default: blocked = 1'b1;
    endcase
  endfunction
  logic mem_go, st_go;
  assign mem_go = cs_rise & byte_end_q & (opc_q == OP_WRITE) & wel_q & ~busy_q; // [RQ7] [RQ18]
  assign st_go = cs_rise & byte_end_q & (opc_q == OP_STAT_WR) & wel_q & ~busy_q
               & ~(arm_q & ~pin_q.wp_n); // [RQ7] [RQ9] [RQ11]
  logic [31:0] tick_q;
  logic [14:0] wr_base_q;
  logic [6:0] wr_cnt_q;
  logic wr_mem_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      tick_q <= '0;
      wr_base_q <= '0;
      wr_cnt_q <= '0;
      wr_mem_q <= 1'b0;
    end else if (mem_go | st_go) begin
      busy_q <= 1'b1; // [RQ8]
      tick_q <= 32'(WRITE_TICKS);
      wr_base_q <= adr_q[14:0];
      wr_cnt_q <= page_cnt_q;
      wr_mem_q <= mem_go;
    end else if (busy_q) begin
      // Protect pin is not looked at here, cycle always completes
      if (tick_q == 32'h1) busy_q <= 1'b0; // [RQ12]
      tick_q <= tick_q - 32'h1;
    end
  end
  // Page commits in one pass at cycle end
  always_ff @(posedge core_clk) begin
    if (busy_q && tick_q == 32'h1 && wr_mem_q) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (7'(i) < wr_cnt_q) begin
          if (!blocked({wr_base_q[14:6], 6'(wr_base_q[5:0] + 6'(i))},
                       {sel_hi_q, sel_lo_q})) // [RQ10]
            mem_q[{wr_base_q[14:6], 6'(wr_base_q[5:0] + 6'(i))}] <= page_q[6'(wr_base_q[5:0] + 6'(i))];
        end
      end
    end
  end
  // Nonvolatile bits modelled by flops cleared by reset and loaded only by an accepted status write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arm_q <= ST_RESET[ST_ARM];
      sel_hi_q <= ST_RESET[ST_SEL_HI];
      sel_lo_q <= ST_RESET[ST_SEL_LO];
    end else if (st_go) begin // [RQ5]
      arm_q <= sh_q[ST_ARM];
      sel_hi_q <= sh_q[ST_SEL_HI];
      sel_lo_q <= sh_q[ST_SEL_LO];
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) wel_q <= 1'b0; // [RQ6]
    else if (mem_go | st_go) wel_q <= 1'b0; // [RQ17]
    else if (opc_done && !busy_q && opc_next == OP_SET_LATCH) wel_q <= 1'b1; // [RQ6]
    else if (opc_done && !busy_q && opc_next == OP_CLR_LATCH) wel_q <= 1'b0; // [RQ6]
  end

  // ----------------------------------------
  // Output shifter
  // ----------------------------------------
  logic rd_active;
  assign rd_active = (opc_q == OP_STAT_RD && bit_q > BIT_OPC_END)
                   || (opc_q == OP_READ && !busy_q && bit_q > BIT_ADR_END);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_q <= '0;
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      busy <= busy_q;
      serial_out_oe_n <= ~(rd_active & ~pin_q.cs_n & ~held); // [RQ19]
      if (pin_q.cs_n) begin
        out_q <= '0;
      end else if (sck_fall && rd_active) begin // [RQ2]
        if (bit_q[2:0] == 3'h0) begin
          out_q <= (opc_q == OP_STAT_RD) ? status << 1 : mem_q[adr_q[14:0]] << 1; // [RQ13]
          serial_out <= (opc_q == OP_STAT_RD) ? status[7] : mem_q[adr_q[14:0]][7];
        end else begin
          serial_out <= out_q[7];
          out_q <= out_q << 1;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_busy_no_wel: assert property (@(posedge core_clk) disable iff (rst)
    $rose(busy_q) |=> !wel_q) else $error("latch not cleared by write"); // [RQ17]
  chk_st_refused: assert property (@(posedge core_clk) disable iff (rst)
    (cs_rise && !wel_q && !busy_q) |=> !busy_q) else $error("write without latch"); // [RQ7]
  chk_wp_block: assert property (@(posedge core_clk) disable iff (rst)
    st_go |-> !(arm_q && !pin_q.wp_n)) else $error("protect pin ignored"); // [RQ11]
  chk_bits_zero: assert property (@(posedge core_clk) disable iff (rst)
    status[6:4] == 3'b000) else $error("reserved bits set"); // [RQ4]
  chk_busy_hold: assert property (@(posedge core_clk) disable iff (rst)
    (busy_q && tick_q > 32'h2) |=> busy_q) else $error("write aborted"); // [RQ12]
  chk_hold_float: assert property (@(posedge core_clk) disable iff (rst)
    held |=> serial_out_oe_n) else $error("output driven in pause"); // [RQ19]
  chk_sel_stable: assert property (@(posedge core_clk) disable iff (rst)
    !st_go |=> $stable(sel_hi_q) && $stable(sel_lo_q))
    else $error("protect bits changed"); // [RQ5]
  chk_wel_set: assert property (@(posedge core_clk) disable iff (rst)
    (opc_done && !busy_q && opc_next == OP_SET_LATCH) |=> wel_q)
    else $error("latch not set"); // [RQ6]
endmodule

// *** bench/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
  input wire logic core_clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so,
  input wire logic so_oe_n
);
  logic paused_oe;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    paused_oe = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Mode 0 frame, MSB first; pause_at below zero means no pause
  task automatic frame(input logic [31:0] tx, input int n, input int pause_at,
    output logic [31:0] rx);
    rx = 32'h0;
    wait_clk(1);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      if (n - 1 - i == pause_at) begin
        // Let the last falling clock edge be seen before pausing
        wait_clk(4);
        hold_n = 1'b0;
        wait_clk(6);
        paused_oe = so_oe_n;
        // Stray clock and data while paused must be ignored
        sck = 1'b1;
        si = ~tx[i];
        wait_clk(4);
        sck = 1'b0;
        wait_clk(4);
        si = tx[i];
        hold_n = 1'b1;
        wait_clk(2);
      end
      wait_clk(4);
      sck = 1'b1;
      // Sampled late in the high phase: output lags the pin by the synchroniser
      wait_clk(4);
      rx = {rx[30:0], so};
      sck = 1'b0;
    end
    wait_clk(4);
    cs_n = 1'b1;
    si = ~si;
    wait_clk(8);
  endtask
endmodule

// *** bench/test_spi_eeprom_status_protect.sv ***
`timescale 1ns/1ps
module test_spi_eeprom_status_protect;
  import eeprom_pkg::*;
  localparam int TICKS = 400;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic protect_pin_n = 1'b1;
  logic sck, cs_n, si, hold_n, so, so_oe_n, busy;
  logic [31:0] rx;
  logic [7:0] v;
  int n_fail = 0;
  int cmp_count = 0;
  int bc;
  spi_eeprom_status_protect #(.WRITE_TICKS(TICKS)) dut_u (.core_clk(core_clk), .rst(rst),
    .shift_clock(sck), .chip_select_n(cs_n), .serial_in(si), .pause_n(hold_n),
    .protect_pin_n(protect_pin_n), .serial_out(so), .serial_out_oe_n(so_oe_n), .busy(busy));
  spi_host_model host_u (.core_clk(core_clk), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic end_sim();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host_u.frame({24'h0, op}, 8, -1, rx);
  endtask
  task automatic st_rd();
    host_u.frame({16'h0, OP_STAT_RD, 8'h00}, 16, -1, rx);
    v = rx[7:0];
  endtask
  // Counts busy cycles; bounded so a stuck flag cannot hang the run
  task automatic wait_idle();
    bc = 0;
    while (busy === 1'b1 && bc < 1000) begin
      @(posedge core_clk);
      #1;
      bc++;
    end
  endtask
  task automatic st_wr(input logic [7:0] d, input logic latch);
    if (latch) cmd(OP_SET_LATCH);
    host_u.frame({16'h0, OP_STAT_WR, d}, 16, -1, rx);
    wait_idle();
  endtask
  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d, input logic latch);
    if (latch) cmd(OP_SET_LATCH);
    host_u.frame({OP_WRITE, a, d}, 32, -1, rx);
    wait_idle();
  endtask
  task automatic mem_rd(input logic [15:0] a);
    host_u.frame({OP_READ, a, 8'h00}, 32, -1, rx);
    v = rx[7:0];
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_latch();
    st_rd();
    chk("status_reset", 8'h00, v);
    cmd(OP_SET_LATCH);
    st_rd();
    chk("status_set", 8'h02, v);
    cmd(OP_CLR_LATCH);
    st_rd();
    chk("status_clr", 8'h00, v);
    st_wr(8'h8C, 1'b0);
    st_rd();
    chk("status_nolatch", 8'h00, v);
    mem_wr(16'h0100, 8'hA5, 1'b1);
    mem_wr(16'h5FFF, 8'h5A, 1'b1);
    mem_wr(16'h6000, 8'h3C, 1'b1);
    st_rd();
    chk("latch_after_wr", 8'h00, v);
    mem_wr(16'h0100, 8'h00, 1'b0);
    mem_rd(16'h0100);
    chk("mem_0100", 8'hA5, v);
  endtask
  task automatic t_status();
    cmd(OP_SET_LATCH);
    host_u.frame({16'h0, OP_STAT_WR, 8'hFF}, 16, -1, rx);
    st_rd();
    chk("busy_bit", 8'h01, v & 8'h01);
    wait_idle();
    st_rd();
    chk("status_ff", 8'h8C, v & 8'hFD);
  endtask
  task automatic t_protect();
    protect_pin_n = 1'b0;
    st_wr(8'h84, 1'b1);
    st_rd();
    chk("pin_refuse", 8'h8C, v & 8'hFD);
    mem_wr(16'h0100, 8'h11, 1'b1);
    mem_rd(16'h0100);
    chk("prot_all", 8'hA5, v);
    protect_pin_n = 1'b1;
    st_wr(8'h84, 1'b1);
    st_rd();
    chk("sel_01", 8'h84, v & 8'hFD);
    protect_pin_n = 1'b0;
    cmd(OP_SET_LATCH);
    host_u.frame({OP_WRITE, 16'h5FFF, 8'h77}, 32, -1, rx);
    protect_pin_n = 1'b1;
    wait_idle();
    chk("busy_len", 8'h1, 8'((bc > TICKS - 40) && (bc <= TICKS)));
    protect_pin_n = 1'b0;
    mem_wr(16'h6000, 8'h99, 1'b1);
    mem_rd(16'h5FFF);
    chk("mem_5fff", 8'h77, v);
    mem_rd(16'h6000);
    chk("mem_6000", 8'h3C, v);
    protect_pin_n = 1'b1;
    st_wr(8'h00, 1'b1);
    protect_pin_n = 1'b0;
    st_wr(8'h0C, 1'b1);
    st_rd();
    chk("unarmed", 8'h0C, v);
  endtask
  task automatic t_pause();
    host_u.frame({16'h0, OP_STAT_RD, 8'h00}, 16, 12, rx);
    chk("pause_rd", 8'h0C, rx[7:0]);
    chk("pause_float", 8'h1, 8'(host_u.paused_oe));
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    host_u.wait_clk(6);
    t_latch();
    t_status();
    t_protect();
    t_pause();
    end_sim();
  end
  initial begin
    #500000;
    n_fail++;
    end_sim();
  end
endmodule
